// ==== dv/adc_serial_readout_port_test.sv ====
// testbench of the serial result readout port
`timescale 1ns/1ps
module adc_serial_readout_port_test;
    logic clock, reset, clkSel, chainIn, convStartN, csN, rdN, hostClk;
    logic [15:0] result;
    logic busy, sclkOut, strobe, sdo, sdoEnN, overrun;
    logic [31:0] spareWord;
    int error_cnt = 0;
    int comparisons = 0;

    // ***
    // design and host model
    // ***
    adc_serial_readout_port i_adc_serial_readout_port
    (
        .clock(clock), .reset(reset), .serial_parallel_select(1'b1),
        .clock_source_select(clkSel), .clock_polarity_invert(1'b0),
        .strobe_polarity_invert(1'b0), .readmode_chain_input(chainIn),
        .convert_start_n(convStartN), .conversionResult(result),
        .chipSelectN(csN), .readEnableN(rdN), .serialClockIn(hostClk),
        .busy(busy), .serialClockOut(sclkOut), .serialClockOutEnN(),
        .frameStrobe(strobe), .frameStrobeEnN(), .serial_result_out(sdo),
        .serialOutEnN(sdoEnN), .read_overrun_flag(overrun)
    );
    host_serial_model i_host_serial_model
    (
        .serialClock(hostClk), .dataIn(sdo), .dataEnN(sdoEnN)
    );

    // 200 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // ***
    // compare, control and end of run
    // ***
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t word %h expected %h", $time, got, exp);
        end
    endtask : check_word

    task automatic check_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
        end
    endtask : check_bit

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test

    // pulse the start low until busy answers
    task automatic start_conv(input logic [15:0] value);
        int n;
        n = 0;
        @(posedge clock);
        result <= value;
        convStartN <= 1'b0;
        while (busy !== 1'b1 && n < 20)
        begin
            @(negedge clock);
            n++;
        end
        check_bit(busy, 1'b1);
        @(posedge clock);
        convStartN <= 1'b1;
    endtask : start_conv

    // wait for busy low, noting any overrun pulse
    task automatic wait_idle(output logic flagSeen);
        int n;
        n = 0;
        flagSeen = 1'b0;
        while (busy !== 1'b0 && n < 1000)
        begin
            @(negedge clock);
            n++;
            flagSeen = flagSeen | (overrun === 1'b1);
        end
        repeat (4)
        begin
            @(negedge clock);
            flagSeen = flagSeen | (overrun === 1'b1);
        end
    endtask : wait_idle

    // ***
    // scenarios
    // ***
    task automatic test_master;
        logic [31:0] word;
        logic prev;
        int bits, n;
        word = '0;
        bits = 0;
        n = 0;
        @(posedge clock);
        clkSel <= 1'b0;
        chainIn <= 1'b0;
        start_conv(16'hA53C);
        prev = sclkOut;
        while ((busy === 1'b1 || bits == 0) && n < 600)
        begin
            @(negedge clock);
            n++;
            if (sclkOut === 1'b1 && prev === 1'b0 && strobe === 1'b1)
            begin
                word = {word[30:0], sdo};
                bits++;
                if (bits == 16)
                    check_bit(busy, 1'b1);
            end
            prev = sclkOut;
        end
        check_word(32'(bits), 32'h0000_0010);
        check_word(word, 32'h0000_A53C);
        check_bit(strobe, 1'b0);
        $display("test_master done");
    endtask : test_master

    task automatic test_slave_after;
        logic [31:0] word;
        logic flag;
        @(posedge clock);
        clkSel <= 1'b1;
        chainIn <= 1'b0;
        start_conv(16'h5AC3);
        wait_idle(flag);
        @(posedge clock);
        csN <= 1'b0;
        rdN <= 1'b0;
        i_host_serial_model.read_bits(17, word);
        check_word(word, 32'h0000_B586);
        @(posedge clock);
        csN <= 1'b1;
        repeat (4) @(negedge clock);
        check_bit(sdoEnN, 1'b1);
        $display("test_slave_after done");
    endtask : test_slave_after

    task automatic test_overrun;
        logic flag;
        @(posedge clock);
        chainIn <= 1'b1;
        csN <= 1'b0;
        start_conv(16'h0F0F);
        fork
            i_host_serial_model.read_bits(4, spareWord);
        join_none
        wait_idle(flag);
        check_bit(flag, 1'b1);
        $display("test_overrun done");
    endtask : test_overrun

    // main sequence
    initial
    begin
        reset = 1'b1;
        clkSel = 1'b0;
        chainIn = 1'b0;
        convStartN = 1'b1;
        csN = 1'b1;
        rdN = 1'b1;
        result = 16'h0000;
        repeat (6) @(posedge clock);
        reset <= 1'b0;
        repeat (4) @(posedge clock);
        test_master;
        test_slave_after;
        test_overrun;
        stop_test;
    end

    // watchdog well beyond the expected run
    initial
    begin
        #100000;
        error_cnt++;
        $display("[FAIL] %0t watchdog expired", $time);
        stop_test;
    end
endmodule : adc_serial_readout_port_test

// ==== dv/host_serial_model.sv ====
// host serial port model: gapped link clock, gathers result bits
`timescale 1ns/1ps
module host_serial_model
(
    // link to the device
    output logic serialClock,
    input wire logic dataIn,
    input wire logic dataEnN
);
    logic lastBit;

    // clock idles low between frames, polarity 0 phase 0
    initial
    begin
        serialClock = 1'b0;
        lastBit = 1'b0;
    end

    // burst of count pulses, 125 ns period, sampled on rising edge
    task automatic read_bits(input int count, output logic [31:0] word);
        word = '0;
        repeat (count)
        begin
            #62.5 serialClock = 1'b1;
            // released line reads as the inverse of the last bit
            lastBit = dataEnN ? ~lastBit : dataIn;
            word = {word[30:0], lastBit};
            #62.5 serialClock = 1'b0;
        end
    endtask : read_bits
endmodule : host_serial_model

// ==== hdl/adc_serial_params.svh ====
// constants of the serial result readout port
`ifndef ADC_SERIAL_PARAMS_SVH
`define ADC_SERIAL_PARAMS_SVH
`define RESULT_BITS 16
`define BIT_CNT_W 5
`define LAST_BIT 5'h0_00F
`define CONV_CYCLES 8'h00_A0
`define CONV_HALF 8'h00_50
`define MCLK_DIV 4'h0_4
`define ZERO16 16'h0000
`endif

// ==== hdl/adc_serial_pkg.sv ====
// types of the serial result readout port
package adc_serial_pkg;
    typedef enum logic [1:0] {IDLE, CONVERT, SHIFT} phase_t;
endpackage : adc_serial_pkg

// ==== hdl/adc_serial_readout_port.sv ====
// serial result readout port of a 16-bit sampling converter
`timescale 1ns/1ps
`include "adc_serial_params.svh"
// Operation
// - serial port active when serial_parallel_select high
// - sixteen bits per result, msb first, one per clock pulse
// - clock_source_select low makes the port generate the serial clock
// - master mode drives a frame valid strobe
// - serial clock and strobe polarity each invertible
// - master data changes with the falling clock edge, held stable across the rising edge
// - readmode_chain_input picks read after or during conversion
// - master read-after mode keeps busy high until sixteen bits out
// - clock_source_select high shifts on the host clock
// - slave read-after needs busy low, chip select and enable low
// - slave accepts continuous or gapped clock, either idle level
// - slave read-after supports host clock up to 40 MHz
// - slave read-after passes cascade input after own result
// - cascade input sampled on edge opposite the shifting edge
// - slave read-during must finish before conversion end, else flag
// - chip select or enable high puts the serial clock, strobe and data outputs in high impedance
// - convert_start_n low starts conversion, busy high until done
module adc_serial_readout_port
(
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // static configuration pins
    input wire logic serial_parallel_select,
    input wire logic clock_source_select,
    input wire logic clock_polarity_invert,
    input wire logic strobe_polarity_invert,
    input wire logic readmode_chain_input,
    // conversion control and result
    input wire logic convert_start_n,
    input wire logic [15:0] conversionResult,
    input wire logic chipSelectN,
    input wire logic readEnableN,
    // host serial clock input
    input wire logic serialClockIn,
    // outputs
    output logic busy,
    output logic serialClockOut,
    output logic serialClockOutEnN,
    output logic frameStrobe,
    output logic frameStrobeEnN,
    output logic serial_result_out,
    output logic serialOutEnN,
    output logic read_overrun_flag
);
    // ************************************************
    // input synchronisers
    // ************************************************
    logic [1:0] sclkSync_reg;
    logic [1:0] chainSync_reg;
    logic [1:0] cnvSync_reg;
    logic [1:0] csSync_reg;
    logic [1:0] rdSync_reg;
    logic sclkLast_reg;
    // two stages for the host clock, chain, start, chip select and read enable inputs
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            sclkSync_reg <= 2'h0;
            chainSync_reg <= 2'h0;
            cnvSync_reg <= 2'h3;
            csSync_reg <= 2'h3;
            rdSync_reg <= 2'h3;
            sclkLast_reg <= 1'b0;
        end
        else
        begin
            sclkSync_reg <= {sclkSync_reg[0], serialClockIn};
            chainSync_reg <= {chainSync_reg[0], readmode_chain_input};
            cnvSync_reg <= {cnvSync_reg[0], convert_start_n};
            csSync_reg <= {csSync_reg[0], chipSelectN};
            rdSync_reg <= {rdSync_reg[0], readEnableN};
            sclkLast_reg <= sclkSync_reg[1];
        end
    end

    logic sclkRise;
    logic sclkFall;
    logic selected;
    logic slaveMode;
    logic readAfter;
    // host clock edges seen by the local clock
    assign sclkRise = sclkSync_reg[1] & ~sclkLast_reg;
    assign sclkFall = ~sclkSync_reg[1] & sclkLast_reg;
    assign selected = ~csSync_reg[1] & ~rdSync_reg[1];
    assign slaveMode = clock_source_select;
    assign readAfter = ~chainSync_reg[1];

    // ************************************************
    // conversion timing
    // ************************************************
    adc_serial_pkg::phase_t phase_reg;
    logic [7:0] convCnt_reg;
    logic convDone;
    logic shiftDone;
    logic holdBusy;
    assign convDone = (phase_reg == adc_serial_pkg::CONVERT)
        && (convCnt_reg == `CONV_CYCLES);
    assign holdBusy = serial_parallel_select & ~slaveMode & readAfter;
    // convert, then optionally shift out before busy falls
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            phase_reg <= adc_serial_pkg::IDLE;
            convCnt_reg <= 8'h00;
        end
        else
        begin
            unique case (phase_reg)
                adc_serial_pkg::IDLE:
                begin
                    convCnt_reg <= 8'h00;
                    if (!cnvSync_reg[1])
                        phase_reg <= adc_serial_pkg::CONVERT;
                end
                adc_serial_pkg::CONVERT:
                begin
                    convCnt_reg <= convCnt_reg + 8'h01;
                    if (convDone)
                        phase_reg <= holdBusy ? adc_serial_pkg::SHIFT
                            : adc_serial_pkg::IDLE;
                end
                adc_serial_pkg::SHIFT:
                    if (shiftDone)
                        phase_reg <= adc_serial_pkg::IDLE;
            endcase
        end
    end

    // busy output from the phase
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            busy <= 1'b0;
        else
            busy <= (phase_reg != adc_serial_pkg::IDLE);
    end

    // ************************************************
    // result latches
    // ************************************************
    logic [15:0] result_reg;
    logic [15:0] previous_reg;
    // capture at end of conversion, keep prior for read-during
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            result_reg <= `ZERO16;
            previous_reg <= `ZERO16;
        end
        else if (convDone)
        begin
            result_reg <= conversionResult;
            previous_reg <= result_reg;
        end
    end

    // ************************************************
    // master clock generation
    // ************************************************
    logic [3:0] divCnt_reg;
    logic tick;
    assign tick = (divCnt_reg == `MCLK_DIV);
    // enable pulse for master half periods
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            divCnt_reg <= 4'h0;
        else
            divCnt_reg <= tick ? 4'h0 : divCnt_reg + 4'h1;
    end

    // ************************************************
    // shift engine
    // ************************************************
    logic [15:0] shift_reg;
    logic [4:0] bitCnt_reg;
    logic active_reg;
    logic mclk_reg;
    logic chainBit_reg;
    logic startShift;
    logic shiftEdge;
    logic sampleEdge;
    // master starts after conversion or at conversion start
    assign startShift = serial_parallel_select & ~active_reg & (slaveMode
        ? (readAfter ? (phase_reg == adc_serial_pkg::IDLE) & selected
                     : (phase_reg == adc_serial_pkg::CONVERT) & selected
                       & (convCnt_reg == 8'h00))
        : (readAfter ? convDone
                     : (phase_reg == adc_serial_pkg::CONVERT)
                       & (convCnt_reg == 8'h00)));
    // slave shifts on falling, samples on rising (cpol 0 cpha 0)
    assign shiftEdge = slaveMode ? sclkFall & selected
        : tick & mclk_reg;
    assign sampleEdge = slaveMode ? sclkRise & selected
        : tick & ~mclk_reg;
    assign shiftDone = active_reg & shiftEdge & (bitCnt_reg == `LAST_BIT);

    // load, count and shift msb first
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            shift_reg <= `ZERO16;
            bitCnt_reg <= 5'h00;
            active_reg <= 1'b0;
            mclk_reg <= 1'b0;
            chainBit_reg <= 1'b0;
        end
        else if (startShift)
        begin
            shift_reg <= readAfter ? (convDone ? conversionResult
                : result_reg) : result_reg;
            bitCnt_reg <= 5'h00;
            active_reg <= 1'b1;
            mclk_reg <= 1'b0;
        end
        else if (active_reg)
        begin
            if (!slaveMode && tick)
                mclk_reg <= ~mclk_reg;
            if (sampleEdge)
                chainBit_reg <= chainSync_reg[1];
            if (shiftEdge)
            begin
                shift_reg <= {shift_reg[14:0],
                    slaveMode & readAfter & chainBit_reg};
                bitCnt_reg <= bitCnt_reg + 5'h01;
                if (bitCnt_reg == `LAST_BIT && !(slaveMode && readAfter))
                    active_reg <= 1'b0;
            end
            if (slaveMode && readAfter && !selected)
                active_reg <= 1'b0; // chain passthrough ends on deselect
        end
    end

    // ************************************************
    // read overrun detection
    // ************************************************
    logic overrun;
    assign overrun = convDone & slaveMode & ~readAfter & active_reg
        & (bitCnt_reg <= `LAST_BIT);

    // ************************************************
    // registered outputs
    // ************************************************
    // polarity, tristate enables and overrun pulse
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            serialClockOut <= 1'b0;
            serialClockOutEnN <= 1'b1;
            frameStrobe <= 1'b0;
            frameStrobeEnN <= 1'b1;
            serial_result_out <= 1'b0;
            serialOutEnN <= 1'b1;
            read_overrun_flag <= 1'b0;
        end
        else
        begin
            serialClockOut <= mclk_reg ^ clock_polarity_invert;
            frameStrobe <= (active_reg & ~slaveMode)
                ^ strobe_polarity_invert;
            serialClockOutEnN <= ~(selected & serial_parallel_select
                & ~slaveMode);
            frameStrobeEnN <= ~(selected & serial_parallel_select
                & ~slaveMode);
            serial_result_out <= shift_reg[15];
            serialOutEnN <= ~(selected & serial_parallel_select);
            read_overrun_flag <= overrun;
        end
    end

    // ************************************************
    // assertions
    // ************************************************
    a_busy_start: assert property (@(posedge clock) disable iff (reset)
        (phase_reg == adc_serial_pkg::IDLE) && !cnvSync_reg[1]
        |=> ##1 busy)
        else $error("busy did not rise after convert start");
    a_hiz_desel: assert property (@(posedge clock) disable iff (reset)
        !selected |=> serialOutEnN)
        else $error("data output driven while deselected");
    a_busy_hold: assert property (@(posedge clock) disable iff (reset)
        phase_reg == adc_serial_pkg::SHIFT |=> busy)
        else $error("busy fell before bits shifted out");
    a_overrun_pulse: assert property (@(posedge clock) disable iff (reset)
        read_overrun_flag |=> !read_overrun_flag)
        else $error("overrun flag not a single pulse");
    a_strobe_span: assert property (@(posedge clock) disable iff (reset)
        !slaveMode && !strobe_polarity_invert && $rose(active_reg)
        |=> frameStrobe)
        else $error("strobe missing during master frame");
    a_master_clk: assert property (@(posedge clock) disable iff (reset)
        !active_reg && !slaveMode |=> $stable(mclk_reg))
        else $error("master clock toggled outside frame");
    a_msb_first: assert property (@(posedge clock) disable iff (reset)
        startShift |=> shift_reg[15] == ($past(readAfter && convDone)
        ? $past(conversionResult[15]) : $past(result_reg[15])))
        else $error("msb not loaded first");
    a_slave_noclk: assert property (@(posedge clock) disable iff (reset)
        slaveMode |-> ##1 (serialClockOutEnN || !selected ||
        !serial_parallel_select))
        else $error("clock driven in slave mode");
    c_master_read: cover property (@(posedge clock) disable iff (reset)
        !slaveMode && shiftDone);
    c_slave_read: cover property (@(posedge clock) disable iff (reset)
        slaveMode && readAfter && shiftEdge);
    c_overrun: cover property (@(posedge clock) disable iff (reset)
        read_overrun_flag);
endmodule : adc_serial_readout_port
